// ---- design/cpm_pkg.sv ----
package cpm_pkg;
    // ****************************************************************
    // bus and data widths
    // ****************************************************************
    localparam int AXI_AW = 8;
    localparam int DATA_W = 24;
    localparam int FRAC_W = 8;
    localparam int FIFO_DEPTH = 16;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_VOL = 8'h04;
    localparam logic [7:0] ADDR_MIXL = 8'h08;
    localparam logic [7:0] ADDR_MIXR = 8'h0C;
    localparam logic [7:0] ADDR_STAT = 8'h10;
    localparam logic [31:0] CTRL_MASK = 32'h0000_7FFF;
    localparam logic [31:0] VOL_MASK = 32'h0000_00FF;
    localparam logic [31:0] MIX_MASK = 32'h003F_3F3F;
    localparam logic [31:0] CTRL_RST = 32'h0000_0101;
    localparam logic [31:0] VOL_RST = 32'h0000_000C;
    localparam logic [31:0] MIX_RST = 32'h0000_0000;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int CTRL_DC_EN = 0;
    localparam int CTRL_DC_SEL = 1;
    localparam int CTRL_WIND_EN = 3;
    localparam int CTRL_WIND_SEL = 4;
    localparam int CTRL_BOOST = 6;
    localparam int CTRL_RAMP_EN = 7;
    localparam int CTRL_RATE = 8;
    localparam int MIX_CAP = 0;
    localparam int MIX_A = 8;
    localparam int MIX_B = 16;
    localparam int STAT_RAMPING = 8;
    localparam int STAT_LOW_PATH = 9;
    localparam int STAT_FIFO = 10;

    // ****************************************************************
    // processing constants
    // ****************************************************************
    localparam logic [7:0] VOL_MUTE = 8'h6D;
    localparam logic [6:0] RATE_MIN = 7'h01;
    localparam logic [6:0] RATE_MAX = 7'h48;
    localparam int DC_K_BASE = 6;
    localparam int WIND_K_BASE = 2;
    localparam int LN_SHIFT = 4;
    localparam int VOL_UP_SHIFT = 2;
    localparam logic [DATA_W-1:0] LN_THRESH = 24'h04_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- design/cpm_capture_mixer.sv ----
`timescale 1ns/1ps

// ********************************************************************
// sample fifo
// ********************************************************************
module cpm_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = cpm_pkg::FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o,
    output logic [$clog2(DEPTH):0] count_o
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [WIDTH-1:0] nxt_mem [DEPTH];
    logic [PW-1:0] wr_ff, rd_ff, nxt_wr, nxt_rd;
    logic [PW:0] cnt_ff, nxt_cnt;
    logic push, pop;

    // full and empty straight from the occupancy count
    assign in_ready_o = cnt_ff != (PW+1)'(DEPTH);
    assign out_valid_o = cnt_ff != '0;
    assign out_data_o = mem_ff[rd_ff];
    assign count_o = cnt_ff;
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // pointer and storage update
    always_comb begin
        nxt_mem = mem_ff;
        nxt_wr = wr_ff;
        nxt_rd = rd_ff;
        nxt_cnt = cnt_ff;
        if (push) begin
            nxt_mem[wr_ff] = in_data_i;
            nxt_wr = wr_ff + 1'b1;
        end
        if (pop) begin
            nxt_rd = rd_ff + 1'b1;
        end
        if (push && !pop) begin
            nxt_cnt = cnt_ff + 1'b1;
        end else if (pop && !push) begin
            nxt_cnt = cnt_ff - 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mem_ff <= '{default: '0};
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end else begin
            mem_ff <= nxt_mem;
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
            cnt_ff <= nxt_cnt;
        end
    end
endmodule // cpm_fifo

// ********************************************************************
// capture path and stereo mixer
// ********************************************************************
module cpm_capture_mixer #(
    parameter int DATA_W = cpm_pkg::DATA_W,
    parameter int FIFO_DEPTH = cpm_pkg::FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [cpm_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [cpm_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [DATA_W-1:0] cap_hi_i,
    input wire logic [DATA_W-1:0] cap_lo_i,
    input wire logic [DATA_W-1:0] ser_a_i,
    input wire logic [DATA_W-1:0] ser_b_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [DATA_W-1:0] mix_left_o,
    output logic [DATA_W-1:0] mix_right_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    import cpm_pkg::*;
    localparam int SW = DATA_W + FRAC_W + 6;
    localparam int FW = $clog2(FIFO_DEPTH) + 1;
    typedef logic signed [SW-1:0] cpm_smp_t;

    // ****************************************************************
    // arithmetic helpers
    // ****************************************************************
    // one first-order high-pass section, pole at 1 - 2^-k
    function automatic cpm_smp_t hp1(cpm_smp_t x, cpm_smp_t x1,
                                     cpm_smp_t y1, int k);
        return x - x1 + y1 - (y1 >>> k);
    endfunction

    // 1 dB steps: mantissa floors, so off-6 dB codes lean quieter
    function automatic cpm_smp_t db_scale(cpm_smp_t x, logic [6:0] att);
        logic [6:0] q;
        logic [15:0] m;
        logic signed [SW+16:0] p;
        q = att / 7'd6;
        case (att - 7'(q * 7'd6))
            7'd0: m = 16'h8000;
            7'd1: m = 16'h7214;
            7'd2: m = 16'h65AC;
            7'd3: m = 16'h5A9D;
            7'd4: m = 16'h50C3;
            default: m = 16'h47FA;
        endcase
        p = x * $signed({1'b0, m});
        return SW'(p >>> (15 + int'(q)));
    endfunction

    // clamp to a signed range of the given bit count
    function automatic cpm_smp_t clamp(cpm_smp_t x, int bits);
        cpm_smp_t hi;
        hi = (cpm_smp_t'(1) <<< (bits - 1)) - 1;
        if (x > hi) return hi;
        if (x < -hi - 1) return -hi - 1;
        return x;
    endfunction

    function automatic cpm_smp_t sx(logic [DATA_W-1:0] v);
        return SW'($signed(v));
    endfunction

    // ****************************************************************
    // register bus
    // ****************************************************************
    logic aw_held_ff, w_held_ff, nxt_aw_held, nxt_w_held;
    logic [7:0] awaddr_ff, nxt_awaddr;
    logic [31:0] wdata_ff, nxt_wdata;
    logic [3:0] wstrb_ff, nxt_wstrb;
    logic bvalid_ff, rvalid_ff, nxt_bvalid, nxt_rvalid;
    logic [1:0] bresp_ff, rresp_ff, nxt_bresp, nxt_rresp;
    logic [31:0] rdata_ff, nxt_rdata, stat_word, wmask;
    logic [31:0] ctrl_ff, vol_ff, mixl_ff, mixr_ff;
    logic [31:0] nxt_ctrl, nxt_vol, nxt_mixl, nxt_mixr;
    logic [7:0] cur_vol_ff, nxt_cur_vol;
    logic [6:0] ramp_cnt_ff, nxt_ramp_cnt;
    logic low_path_ff, nxt_low_path;
    logic [FW-1:0] fifo_cnt;

    assign s_axi_awready = !aw_held_ff && !bvalid_ff;
    assign s_axi_wready = !w_held_ff && !bvalid_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rresp = rresp_ff;
    assign s_axi_rdata = rdata_ff;
    assign stat_word = {17'h0_0000, 5'(fifo_cnt), low_path_ff,
                        cur_vol_ff != vol_ff[7:0], cur_vol_ff};
    assign wmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}},
                    {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};

    // address and data latch in either order; write once both held
    always_comb begin
        nxt_aw_held = aw_held_ff;
        nxt_w_held = w_held_ff;
        nxt_awaddr = awaddr_ff;
        nxt_wdata = wdata_ff;
        nxt_wstrb = wstrb_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        nxt_ctrl = ctrl_ff;
        nxt_vol = vol_ff;
        nxt_mixl = mixl_ff;
        nxt_mixr = mixr_ff;
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_aw_held = 1'b1;
            nxt_awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_w_held = 1'b1;
            nxt_wdata = s_axi_wdata;
            nxt_wstrb = s_axi_wstrb;
        end
        if (aw_held_ff && w_held_ff) begin
            nxt_aw_held = 1'b0;
            nxt_w_held = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = RESP_OKAY;
            case (awaddr_ff)
                ADDR_CTRL: nxt_ctrl = ((ctrl_ff & ~wmask) |
                                       (wdata_ff & wmask)) & CTRL_MASK;
                ADDR_VOL: nxt_vol = ((vol_ff & ~wmask) |
                                     (wdata_ff & wmask)) & VOL_MASK;
                ADDR_MIXL: nxt_mixl = ((mixl_ff & ~wmask) |
                                       (wdata_ff & wmask)) & MIX_MASK;
                ADDR_MIXR: nxt_mixr = ((mixr_ff & ~wmask) |
                                       (wdata_ff & wmask)) & MIX_MASK;
                ADDR_STAT: nxt_bresp = RESP_OKAY; // read-only, ignored
                default: nxt_bresp = RESP_SLVERR;
            endcase
        end
        if (bvalid_ff && s_axi_bready) begin
            nxt_bvalid = 1'b0;
        end
        if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_rvalid = 1'b1;
            nxt_rresp = RESP_OKAY;
            case (s_axi_araddr)
                ADDR_CTRL: nxt_rdata = ctrl_ff;
                ADDR_VOL: nxt_rdata = vol_ff;
                ADDR_MIXL: nxt_rdata = mixl_ff;
                ADDR_MIXR: nxt_rdata = mixr_ff;
                ADDR_STAT: nxt_rdata = stat_word;
                default: begin
                    nxt_rdata = 32'h0000_0000;
                    nxt_rresp = RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= RESP_OKAY;
            ctrl_ff <= CTRL_RST;
            vol_ff <= VOL_RST;
            mixl_ff <= MIX_RST;
            mixr_ff <= MIX_RST;
        end else begin
            aw_held_ff <= nxt_aw_held;
            w_held_ff <= nxt_w_held;
            awaddr_ff <= nxt_awaddr;
            wdata_ff <= nxt_wdata;
            wstrb_ff <= nxt_wstrb;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
            ctrl_ff <= nxt_ctrl;
            vol_ff <= nxt_vol;
            mixl_ff <= nxt_mixl;
            mixr_ff <= nxt_mixr;
        end
    end

    // ****************************************************************
    // capture path
    // ****************************************************************
    logic take, use_lo, mute;
    logic [1:0] dc_sel, wind_sel;
    logic [6:0] rate_eff;
    logic [7:0] tgt_vol;
    cpm_smp_t x0, dc_out, wind_out, boost_out, vol_out, cap_s;
    cpm_smp_t dc_x_ff, dc_y_ff, nxt_dc_x, nxt_dc_y;
    cpm_smp_t wx_ff [4], wy_ff [4], nxt_wx [4], nxt_wy [4], ws [5];
    cpm_smp_t mix_l, mix_r;
    logic [2*DATA_W-1:0] mix_word;

    assign take = in_valid_i && in_ready_o;
    assign dc_sel = ctrl_ff[CTRL_DC_SEL +: 2];
    assign wind_sel = ctrl_ff[CTRL_WIND_SEL +: 2];
    assign tgt_vol = (vol_ff[7:0] > VOL_MUTE) ? VOL_MUTE : vol_ff[7:0];
    assign mute = cur_vol_ff == VOL_MUTE;

    // quiet input rides the low-noise path, loud the wide one
    assign use_lo = $signed(cap_hi_i) < $signed(LN_THRESH) &&
                    $signed(cap_hi_i) > -$signed(LN_THRESH);

    // filters, boost and volume, evaluated for the sample being taken
    always_comb begin
        x0 = use_lo ? (sx(cap_lo_i) <<< (FRAC_W - LN_SHIFT))
                    : (sx(cap_hi_i) <<< FRAC_W);
        nxt_dc_y = hp1(x0, dc_x_ff, dc_y_ff, DC_K_BASE + int'(dc_sel));
        dc_out = ctrl_ff[CTRL_DC_EN] ? nxt_dc_y : x0;
        ws[0] = dc_out;
        for (int i = 0; i < 4; i++) begin
            nxt_wy[i] = hp1(ws[i], wx_ff[i], wy_ff[i],
                            WIND_K_BASE + int'(wind_sel));
            ws[i+1] = nxt_wy[i];
        end
        wind_out = ctrl_ff[CTRL_WIND_EN] ? ws[4] : dc_out;
        boost_out = ctrl_ff[CTRL_BOOST] ?
                    clamp(wind_out * 10, DATA_W + FRAC_W) : wind_out;
        vol_out = mute ? '0 : clamp(db_scale(boost_out <<< VOL_UP_SHIFT,
                  cur_vol_ff[6:0]), DATA_W + FRAC_W);
        cap_s = clamp(vol_out >>> FRAC_W, DATA_W);
        nxt_dc_x = x0;
        if (!ctrl_ff[CTRL_DC_EN]) begin
            nxt_dc_y = '0;
        end
        for (int i = 0; i < 4; i++) begin
            nxt_wx[i] = ws[i];
            if (!ctrl_ff[CTRL_WIND_EN]) begin
                nxt_wy[i] = '0;
            end
        end
        nxt_low_path = take ? use_lo : low_path_ff;
    end

    // volume tracking; limitation: ramp counts taken samples only
    always_comb begin
        rate_eff = ctrl_ff[CTRL_RATE +: 7];
        if (rate_eff < RATE_MIN) rate_eff = RATE_MIN;
        if (rate_eff > RATE_MAX) rate_eff = RATE_MAX;
        nxt_cur_vol = cur_vol_ff;
        nxt_ramp_cnt = ramp_cnt_ff;
        if (take) begin
            if (!ctrl_ff[CTRL_RAMP_EN]) begin
                nxt_cur_vol = tgt_vol;
                nxt_ramp_cnt = '0;
            end else if (cur_vol_ff == tgt_vol) begin
                nxt_ramp_cnt = '0;
            end else if (ramp_cnt_ff + 7'd1 >= rate_eff) begin
                nxt_ramp_cnt = '0;
                nxt_cur_vol = (cur_vol_ff < tgt_vol) ? cur_vol_ff + 8'd1
                                                     : cur_vol_ff - 8'd1;
            end else begin
                nxt_ramp_cnt = ramp_cnt_ff + 7'd1;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            dc_x_ff <= '0;
            dc_y_ff <= '0;
            wx_ff <= '{default: '0};
            wy_ff <= '{default: '0};
            cur_vol_ff <= VOL_RST[7:0];
            ramp_cnt_ff <= '0;
            low_path_ff <= 1'b0;
        end else begin
            if (take) begin
                dc_x_ff <= nxt_dc_x;
                dc_y_ff <= nxt_dc_y;
                wx_ff <= nxt_wx;
                wy_ff <= nxt_wy;
            end
            cur_vol_ff <= nxt_cur_vol;
            ramp_cnt_ff <= nxt_ramp_cnt;
            low_path_ff <= nxt_low_path;
        end
    end

    // ****************************************************************
    // mixer
    // ****************************************************************
    // fourteen spare bits above the word: three inputs cannot wrap
    always_comb begin
        mix_l = db_scale(cap_s, 7'(mixl_ff[MIX_CAP +: 6])) +
                db_scale(sx(ser_a_i), 7'(mixl_ff[MIX_A +: 6])) +
                db_scale(sx(ser_b_i), 7'(mixl_ff[MIX_B +: 6]));
        mix_r = db_scale(cap_s, 7'(mixr_ff[MIX_CAP +: 6])) +
                db_scale(sx(ser_a_i), 7'(mixr_ff[MIX_A +: 6])) +
                db_scale(sx(ser_b_i), 7'(mixr_ff[MIX_B +: 6]));
        mix_word = {DATA_W'(clamp(mix_l, DATA_W)),
                    DATA_W'(clamp(mix_r, DATA_W))};
    end

    // a stalled converter side backs up into in_ready_o
    cpm_fifo #(.WIDTH(2 * DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(in_valid_i),
        .in_ready_o(in_ready_o),
        .in_data_i(mix_word),
        .out_valid_o(out_valid_o),
        .out_ready_i(out_ready_i),
        .out_data_o({mix_left_o, mix_right_o}),
        .count_o(fifo_cnt)
    );

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_DC_OFF_CLEARS: assert property (!ctrl_ff[CTRL_DC_EN] && take |=> dc_y_ff == '0) else $error("dc state kept");
    AST_WIND_BYPASS: assert property (!ctrl_ff[CTRL_WIND_EN] |-> wind_out == dc_out) else $error("wind not bypassed");
    AST_PATH_FLAG: assert property (take |=> low_path_ff == $past(use_lo)) else $error("path flag wrong");
    AST_BOOST: assert property (ctrl_ff[CTRL_BOOST] && wind_out == cpm_smp_t'(32'h0010_0000) |-> boost_out == cpm_smp_t'(32'h00A0_0000)) else $error("boost wrong");
    AST_MUTE_ZERO: assert property (mute |-> cap_s == '0) else $error("mute not zero");
    AST_RAMP_ONE_STEP: assert property (ctrl_ff[CTRL_RAMP_EN] && cur_vol_ff != $past(cur_vol_ff) |-> cur_vol_ff - $past(cur_vol_ff) == 8'd1 || $past(cur_vol_ff) - cur_vol_ff == 8'd1) else $error("ramp skipped");
    AST_RAMP_WAIT: assert property (ctrl_ff[CTRL_RAMP_EN] && take && cur_vol_ff != tgt_vol && ramp_cnt_ff + 7'd1 < rate_eff |=> cur_vol_ff == $past(cur_vol_ff)) else $error("ramp early");
    AST_NO_RAMP: assert property (!ctrl_ff[CTRL_RAMP_EN] && take |=> cur_vol_ff == $past(tgt_vol)) else $error("volume late");
    AST_HALF_EXACT: assert property (db_scale(cpm_smp_t'(4096), 7'd6) == cpm_smp_t'(2048)) else $error("6 dB not half");
    AST_SAT_HIGH: assert property (take && mix_l > cpm_smp_t'(8388607) |-> mix_word[2*DATA_W-1 -: DATA_W] == 24'h7F_FFFF) else $error("no saturation");
    AST_BRESP_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");

    COV_RAMP: cover property (ctrl_ff[CTRL_RAMP_EN] && cur_vol_ff != $past(cur_vol_ff));
    COV_SAT: cover property (take && mix_l > cpm_smp_t'(8388607));
    COV_FULL: cover property (in_valid_i && !in_ready_o);
    COV_LOW: cover property (take && use_lo);
endmodule // cpm_capture_mixer

// ---- verification/cpm_sink_model.sv ----
`timescale 1ns/1ps
// playback converter side: drains mix words, stalls on request
module cpm_sink_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic stall_i,
    input wire logic valid_i,
    input wire logic [23:0] left_i,
    input wire logic [23:0] right_i,
    output logic ready_o,
    output logic got_o,
    output logic [23:0] left_o,
    output logic [23:0] right_o
);
    // no word is taken in reset or while stalled
    assign ready_o = !stall_i && !rst_i;
    // keep the last word taken so the bench can judge it
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            got_o <= 1'b0;
            left_o <= 24'h00_0000;
            right_o <= 24'h00_0000;
        end else begin
            got_o <= valid_i && ready_o;
            if (valid_i && ready_o) begin
                left_o <= left_i;
                right_o <= right_i;
            end
        end
    end
endmodule // cpm_sink_model

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    import cpm_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, awv = 1'b0, wv = 1'b0, arv = 1'b0;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0000_0000, rd;
    logic [23:0] ch = 24'h00_0000, ca = 24'h00_0000, cb = 24'h00_0000;
    logic [23:0] ml, mr, gl, gr;
    logic inv = 1'b0, stall = 1'b0;
    logic awr, wr_r, arr, bv, rv, inr, ov, ordy, got;
    logic [1:0] br, rr;
    int fails = 0, n_tests = 0, cyc = 0;
    cpm_capture_mixer u_dut (.clk_i(clk_i), .rst_i(rst_i),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wr_r), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
        .s_axi_rvalid(rv), .s_axi_rready(1'b1), .cap_hi_i(ch),
        .cap_lo_i(ch << 4), .ser_a_i(ca), .ser_b_i(cb), .in_valid_i(inv),
        .in_ready_o(inr), .mix_left_o(ml), .mix_right_o(mr),
        .out_valid_o(ov), .out_ready_i(ordy));
    cpm_sink_model u_sink (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall),
        .valid_i(ov), .left_i(ml), .right_i(mr), .ready_o(ordy),
        .got_o(got), .left_o(gl), .right_o(gr));
    // free running clock, 10 ns
    always #5 clk_i = ~clk_i;
    // hang guard: whole run needs well under 10k cycles
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            conclude();
        end
    end
    task automatic conclude();
        if (fails == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("mismatch t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk_smp(input logic [23:0] e);
        chk_reg({8'h00, gl}, {8'h00, e});
        chk_reg({8'h00, gr}, {8'h00, e});
    endtask
    // bready stays high, so the response is taken where bvalid is seen
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] e);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        do begin
            @(posedge clk_i);
            if (awv && awr) awv <= 1'b0;
            if (wv && wr_r) wv <= 1'b0;
        end while (!bv);
        chk_reg({30'h0, br}, {30'h0, e});
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed,
                          input logic [1:0] e);
        ara <= a;
        arv <= 1'b1;
        do begin
            @(posedge clk_i);
            if (arv && arr) arv <= 1'b0;
        end while (!rv);
        chk_reg(rd, ed);
        chk_reg({30'h0, rr}, {30'h0, e});
    endtask
    // one frame in, wait until the converter side has taken its word
    task automatic smp(input logic [23:0] c, a, b);
        ch <= c;
        ca <= a;
        cb <= b;
        inv <= 1'b1;
        do @(posedge clk_i); while (!inr);
        inv <= 1'b0;
        do @(posedge clk_i); while (!got);
    endtask
    // stalled converter: 16 words fit, then input is refused
    task automatic fill_drain();
        int i, n;
        n = 0;
        stall <= 1'b1;
        ch <= 24'h00_0100;
        ca <= 24'h00_0000;
        inv <= 1'b1;
        for (i = 0; i < 16; i++) do @(posedge clk_i); while (!inr);
        // a seventeenth frame stands offered and must be refused
        @(posedge clk_i);
        chk_reg({31'h0, inr}, 32'h0000_0000);
        inv <= 1'b0;
        stall <= 1'b0;
        repeat (40) begin
            @(posedge clk_i);
            if (got) n++;
        end
        chk_reg(n, 16);
        chk_smp(24'h00_0100);
    endtask
    // a steady input must die away, a fresh step must pass through
    task automatic decay(input logic [31:0] ctl);
        axi_wr(ADDR_CTRL, ctl, RESP_OKAY);
        repeat (300) smp(24'h00_1000, 24'h00_0000, 24'h00_0000);
        chk_reg({31'h0, $signed(gl) < 256 && $signed(gl) > -256}, 1);
        smp(24'h00_2000, 24'h00_0000, 24'h00_0000);
        chk_reg({31'h0, gl > 24'h00_0800 && gl < 24'h00_1100}, 1);
    endtask
    // ramp rate 3: one volume step per three taken samples
    task automatic ramp();
        axi_wr(ADDR_CTRL, 32'h0000_0380, RESP_OKAY);
        axi_wr(ADDR_VOL, 32'h0000_000F, RESP_OKAY);
        repeat (3) smp(24'h00_1000, 24'h00_0000, 24'h00_0000);
        axi_rd(ADDR_STAT, 32'h0000_030D, RESP_OKAY);
        repeat (6) smp(24'h00_1000, 24'h00_0000, 24'h00_0000);
        axi_rd(ADDR_STAT, 32'h0000_020F, RESP_OKAY);
    endtask
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        axi_rd(ADDR_CTRL, CTRL_RST, RESP_OKAY);
        axi_rd(ADDR_VOL, VOL_RST, RESP_OKAY);
        axi_rd(8'h14, 32'h0000_0000, RESP_SLVERR);
        axi_wr(8'h14, 32'h0000_0001, RESP_SLVERR);
        axi_wr(ADDR_CTRL, 32'h0000_0000, RESP_OKAY);
        smp(24'h00_1000, 24'h00_0200, 24'h00_0030);
        chk_smp(24'h00_1230);
        smp(24'h10_0000, 24'h00_0000, 24'h00_0000);
        chk_smp(24'h10_0000);
        smp(24'h70_0000, 24'h70_0000, 24'h00_0000);
        chk_smp(24'h7F_FFFF);
        smp(24'h90_0000, 24'h90_0000, 24'h00_0000);
        chk_smp(24'h80_0000);
        fill_drain();
        axi_wr(ADDR_MIXL, 32'h0000_0C06, RESP_OKAY);
        smp(24'h00_2000, 24'h00_4000, 24'h00_0100);
        chk_reg({8'h00, gl}, 32'h0000_2100);
        chk_reg({8'h00, gr}, 32'h0000_6100);
        axi_wr(ADDR_MIXL, 32'h0000_0001, RESP_OKAY);
        smp(24'h40_0000, 24'h00_0000, 24'h00_0000);
        chk_reg({31'h0, gl < 24'h39_0A36 && gl > 24'h38_0000}, 1);
        axi_wr(ADDR_MIXL, 32'h0000_0000, RESP_OKAY);
        axi_wr(ADDR_VOL, {24'h0, VOL_MUTE}, RESP_OKAY);
        smp(24'h00_1000, 24'h00_0000, 24'h00_0000);
        smp(24'h00_1000, 24'h00_0010, 24'h00_0020);
        chk_smp(24'h00_0030);
        axi_wr(ADDR_VOL, 32'h0000_0000, RESP_OKAY);
        smp(24'h00_1000, 24'h00_0000, 24'h00_0000);
        smp(24'h00_1000, 24'h00_0000, 24'h00_0000);
        chk_smp(24'h00_4000);
        axi_wr(ADDR_VOL, 32'h0000_000C, RESP_OKAY);
        axi_wr(ADDR_CTRL, 32'h0000_0040, RESP_OKAY);
        smp(24'h00_1000, 24'h00_0000, 24'h00_0000);
        smp(24'h00_1000, 24'h00_0000, 24'h00_0000);
        chk_smp(24'h00_A000);
        decay(32'h0000_0001);
        decay(32'h0000_0008);
        ramp();
        conclude();
    end
endmodule // testbench
